// [hw/pdxg_regs.vh]
// Register map, field layout, reset values and timing counts of the duty-extreme gate control.
`ifndef PDXG_REGS_VH
`define PDXG_REGS_VH
`define PDXG_ADDR_CTRL        12'h000
`define PDXG_ADDR_FW_PROT     12'h004
`define PDXG_ADDR_ACT_PROT    12'h008
`define PDXG_ADDR_ICHG_ACT    12'h00C
`define PDXG_ADDR_IDCHG_ACT   12'h010
`define PDXG_ADDR_ICHG_FW     12'h014
`define PDXG_ADDR_STATUS      12'h018
`define PDXG_ADDR_TIMES       12'h01C
`define PDXG_ADDR_CURRENT     12'h020
`define PDXG_CTRL_MODE_LSB    0
`define PDXG_CTRL_MODE_MSB    1
`define PDXG_CTRL_GENMODE     2
`define PDXG_CTRL_GEN_DET_EN  3
`define PDXG_CTRL_BANK        4
`define PDXG_CTRL_RESET       32'h0000_0009
`define PDXG_FW_PROT_RESET    32'h0000_0028
`define PDXG_ACT_PROT_RESET   32'h0000_0028
`define PDXG_CODE_RESET       32'h0000_0000
`define PDXG_CODE_MSB         4
`define PDXG_CFG_FW_LSB       5
`define PDXG_CFG_FW_MSB       9
`define PDXG_CFG_INIT_LSB     10
`define PDXG_CFG_INIT_MSB     14
`define PDXG_CNT_W            16
`define PDXG_CNT_MAX          16'hFFFF
`define PDXG_MODE_OFF         2'h0
`define PDXG_MODE_LS          2'h1
`define PDXG_MODE_HS          2'h2
`define PDXG_MODE_OFF2        2'h3
`endif

// [hw/pdxg_period_meter.v]
// Measures the on-time and off-time of the PWM input in clock cycles.
`timescale 1ns/1ps
`include "pdxg_regs.vh"
module pdxg_period_meter (
   input  wire                    pclk,
   input  wire                    presetn,
   input  wire                    pwm_in,
   output reg  [`PDXG_CNT_W-1:0]  on_time,
   output reg  [`PDXG_CNT_W-1:0]  off_time,
   output reg                     period_done,
   output reg                     pwm_prev
);
   reg [`PDXG_CNT_W-1:0] run_count;
   // Saturating count keeps a stuck input from wrapping into a short period.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_count   <= 16'h0000;
         on_time     <= 16'h0000;
         off_time    <= 16'h0000;
         period_done <= 1'b0;
         pwm_prev    <= 1'b0;
      end else begin
         pwm_prev    <= pwm_in;
         period_done <= 1'b0;
         if (pwm_in != pwm_prev) begin
            run_count <= 16'h0001;
            if (pwm_prev) begin
               on_time <= run_count;
            end else begin
               off_time    <= run_count;
               period_done <= 1'b1;
            end
         end else if (run_count != `PDXG_CNT_MAX) begin
            run_count <= run_count + 16'h0001;
         end
      end
   end
endmodule

// [hw/pdxg_delay_line.v]
// Delays a level by a programmable number of clock cycles using edge timestamps.
`timescale 1ns/1ps
`include "pdxg_regs.vh"
module pdxg_delay_line (
   input  wire                    pclk,
   input  wire                    presetn,
   input  wire                    din,
   input  wire [`PDXG_CNT_W-1:0]  delay,
   output reg                     dout
);
   localparam DEPTH = 8;

   reg [`PDXG_CNT_W-1:0]  stamp [0:DEPTH-1];
   reg                    level [0:DEPTH-1];
   reg                    din_q;
   reg [`PDXG_CNT_W-1:0]  now;
   reg [2:0]              head;
   reg [2:0]              tail;
   reg [3:0]              fill;

   wire [`PDXG_CNT_W-1:0] age     = now - stamp[head];
   wire                   pop     = (fill != 4'h0) && (age >= delay);
   wire                   edge_in = (din != din_q) && (delay != 16'h0000);
   wire                   full    = (fill == 4'h8);
   wire                   wr_new  = edge_in && (!full || pop);
   wire                   wr_over = edge_in && full && !pop;
   wire [2:0]             last    = tail - 3'h1;

   // Every input edge is queued with its time stamp, so a pulse shorter than the delay
   // still comes out whole. With more than eight edges in flight the newest edge
   // overwrites the last queued one: a short pulse is lost, but the final level is kept.
   always @(posedge pclk) begin
      if (wr_new) begin
         stamp[tail] <= now;
         level[tail] <= din;
      end else if (wr_over) begin
         stamp[last] <= now;
         level[last] <= din;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_q <= 1'b0;
         now   <= 16'h0000;
         head  <= 3'h0;
         tail  <= 3'h0;
         fill  <= 4'h0;
         dout  <= 1'b0;
      end else begin
         din_q <= din;
         now   <= now + 16'h0001;
         if (delay == 16'h0000) begin
            dout <= din;
            head <= tail;
            fill <= 4'h0;
         end else begin
            if (pop) begin
               dout <= level[head];
               head <= head + 3'h1;
            end
            if (wr_new) begin
               tail <= tail + 3'h1;
            end
            if (wr_new && !pop) begin
               fill <= fill + 4'h1;
            end else if (pop && !wr_new) begin
               fill <= fill - 4'h1;
            end
         end
      end
   end
endmodule

// [hw/pdxg_gate_ctrl.v]
// Top of the duty-extreme PWM half-bridge gate control with its APB register file.
`timescale 1ns/1ps
`include "pdxg_regs.vh"
module pdxg_gate_ctrl (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   input  wire         pwm_in,
   output reg          gate_high_on,
   output reg          gate_low_on,
   output reg  [4:0]   high_charge_code,
   output reg  [4:0]   high_discharge_code,
   output reg  [4:0]   low_charge_code,
   output reg  [4:0]   low_discharge_code,
   output reg          timing_valid,
   output reg          generator_detect_enable
);
   localparam [3:0] ST_IDLE    = 4'b0001;
   localparam [3:0] ST_NORMAL  = 4'b0010;
   localparam [3:0] ST_HIGH_DC = 4'b0100;
   localparam [3:0] ST_LOW_DC  = 4'b1000;

   reg  [1:0]              half_bridge_mode_select;
   reg                     generator_mode;
   reg                     reg_bank;
   reg  [`PDXG_CNT_W-1:0]  freewheel_protection_time;
   reg  [`PDXG_CNT_W-1:0]  active_protection_time;
   reg  [14:0]             active_charge_current_cfg;
   reg  [14:0]             active_discharge_current_cfg;
   reg  [14:0]             freewheel_current_cfg;
   reg  [3:0]              state;
   reg  [3:0]              next_state;
   reg                     extreme_seen;

   wire [`PDXG_CNT_W-1:0]  on_time;
   wire [`PDXG_CNT_W-1:0]  off_time;
   wire                    period_done;
   wire                    pwm_now;
   wire                    act_cmd;
   wire                    fw_cmd;
   wire                    ext_cmd;
   wire [`PDXG_CNT_W-1:0]  ext_delay;

   // Picks the five-bit code field out of a current configuration; the analog driver turns it into 32 steps.
   function [4:0] pdxg_code;
      input [14:0] cfg;
      input [1:0]  field;
      begin
         case (field)
            2'h0:    pdxg_code = cfg[`PDXG_CODE_MSB:0];
            2'h1:    pdxg_code = cfg[`PDXG_CFG_FW_MSB:`PDXG_CFG_FW_LSB];
            2'h2:    pdxg_code = cfg[`PDXG_CFG_INIT_MSB:`PDXG_CFG_INIT_LSB];
            default: pdxg_code = 5'h00;
         endcase
      end
   endfunction

   pdxg_period_meter u_meter (
      .pclk        (pclk),
      .presetn     (presetn),
      .pwm_in      (pwm_in),
      .on_time     (on_time),
      .off_time    (off_time),
      .period_done (period_done),
      .pwm_prev    (pwm_now)
   );

   // Generator mode feeds the complement of the external input to the protection delay lines and the normal-timing check.
   wire pwm_eff = generator_mode ? ~pwm_now : pwm_now;
   wire [`PDXG_CNT_W-1:0] eff_on  = generator_mode ? off_time : on_time;
   wire [`PDXG_CNT_W-1:0] eff_off = generator_mode ? on_time : off_time;

   // Active command rises one active protection time after the effective PWM input rises.
   pdxg_delay_line u_act (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (pwm_eff),
      .delay   (active_protection_time),
      .dout    (act_cmd)
   );

   pdxg_delay_line u_fw (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (~pwm_eff),
      .delay   (freewheel_protection_time),
      .dout    (fw_cmd)
   );

   assign ext_delay = (state == ST_HIGH_DC) ? freewheel_protection_time
                                            : active_protection_time;
   pdxg_delay_line u_ext (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (pwm_now),
      .delay   (ext_delay),
      .dout    (ext_cmd)
   );

   // Classification runs once per period, at the end of each off phase.
   always @* begin
      next_state = state;
      if (period_done) begin
         if (off_time < active_protection_time)
            next_state = ST_HIGH_DC;
         else if (on_time < freewheel_protection_time)
            next_state = ST_LOW_DC;
         else if ((eff_on > freewheel_protection_time) &&
                  (eff_off > active_protection_time))
            next_state = ST_NORMAL;
      end
      case (state)
         ST_IDLE, ST_NORMAL, ST_HIGH_DC, ST_LOW_DC: next_state = next_state;
         default:                                   next_state = ST_IDLE;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= ST_IDLE;
         extreme_seen <= 1'b0;
      end else begin
         state <= next_state;
         // Sticky until software clears it; the clear is ignored while next_state is ST_HIGH_DC or ST_LOW_DC.
         if (next_state == ST_HIGH_DC || next_state == ST_LOW_DC)
            extreme_seen <= 1'b1;
         else if (psel && penable && pwrite && paddr == `PDXG_ADDR_STATUS && pwdata[0])
            extreme_seen <= 1'b0;
      end
   end

   // Gate commands and current codes.
   reg next_high;
   reg next_low;
   reg sel_is_high;
   always @* begin
      sel_is_high = (half_bridge_mode_select == `PDXG_MODE_HS);
      next_high   = 1'b0;
      next_low    = 1'b0;
      case (state)
         ST_NORMAL: begin
            // In generator mode the selected MOSFET freewheels and the opposite is active.
            // Each command waits until the other is released, so unequal protection
            // times can never turn both MOSFETs on together.
            if (sel_is_high ^ generator_mode) begin
               next_high = act_cmd & ~fw_cmd;
               next_low  = fw_cmd & ~act_cmd;
            end else begin
               next_high = fw_cmd & ~act_cmd;
               next_low  = act_cmd & ~fw_cmd;
            end
         end
         ST_HIGH_DC, ST_LOW_DC: begin
            // Opposite MOSFET stays off: passive freewheel.
            next_high = sel_is_high & ext_cmd;
            next_low  = ~sel_is_high & ext_cmd;
         end
         default: begin
            next_high = 1'b0;
            next_low  = 1'b0;
         end
      endcase
      if (half_bridge_mode_select == `PDXG_MODE_OFF ||
          half_bridge_mode_select == `PDXG_MODE_OFF2) begin
         next_high = 1'b0;
         next_low  = 1'b0;
      end
   end

   wire [4:0] act_chg  = pdxg_code(active_charge_current_cfg, 2'h0);
   wire [4:0] act_dchg = pdxg_code(active_discharge_current_cfg, 2'h0);
   wire [4:0] fw_chg   = pdxg_code(freewheel_current_cfg, 2'h1);
   wire [4:0] fw_dchg  = pdxg_code(freewheel_current_cfg, 2'h1);
   wire       high_is_act = (state == ST_NORMAL) ? (sel_is_high ^ generator_mode)
                                                 : sel_is_high;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_high_on        <= 1'b0;
         gate_low_on         <= 1'b0;
         high_charge_code    <= 5'h00;
         high_discharge_code <= 5'h00;
         low_charge_code     <= 5'h00;
         low_discharge_code  <= 5'h00;
         timing_valid        <= 1'b0;
      end else begin
         gate_high_on <= next_high;
         gate_low_on  <= next_low;
         // codes select one of 32 steps in the analog driver.
         high_charge_code    <= high_is_act ? act_chg : fw_chg;
         high_discharge_code <= high_is_act ? act_dchg : fw_dchg;
         low_charge_code     <= high_is_act ? fw_chg : act_chg;
         low_discharge_code  <= high_is_act ? fw_dchg : act_dchg;
         timing_valid        <= (state == ST_NORMAL);
      end
   end

   // APB slave: zero wait states, unmapped addresses answer with pslverr.
   reg mapped;
   always @* begin
      case (paddr)
         `PDXG_ADDR_CTRL, `PDXG_ADDR_FW_PROT, `PDXG_ADDR_ACT_PROT, `PDXG_ADDR_ICHG_ACT,
         `PDXG_ADDR_IDCHG_ACT, `PDXG_ADDR_ICHG_FW, `PDXG_ADDR_STATUS, `PDXG_ADDR_TIMES,
         `PDXG_ADDR_CURRENT: mapped = 1'b1;
         default:            mapped = 1'b0;
      endcase
   end

   wire setup = psel && !penable;
   wire wr    = psel && penable && pwrite && pready;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready                       <= 1'b0;
         pslverr                      <= 1'b0;
         prdata                       <= 32'h0000_0000;
         half_bridge_mode_select      <= 2'h1;
         generator_mode               <= 1'b0;
         generator_detect_enable      <= 1'b1;
         reg_bank                     <= 1'b0;
         freewheel_protection_time    <= 16'h0028;
         active_protection_time       <= 16'h0028;
         active_charge_current_cfg    <= 15'h0000;
         active_discharge_current_cfg <= 15'h0000;
         freewheel_current_cfg        <= 15'h0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite) begin
            case (paddr)
               `PDXG_ADDR_CTRL:      prdata <= {27'h0, reg_bank, generator_detect_enable,
                                                generator_mode, half_bridge_mode_select};
               `PDXG_ADDR_FW_PROT:   prdata <= {16'h0000, freewheel_protection_time};
               `PDXG_ADDR_ACT_PROT:  prdata <= {16'h0000, active_protection_time};
               `PDXG_ADDR_ICHG_ACT:  prdata <= {17'h0, active_charge_current_cfg};
               `PDXG_ADDR_IDCHG_ACT: prdata <= {17'h0, active_discharge_current_cfg};
               `PDXG_ADDR_ICHG_FW:   prdata <= {17'h0, freewheel_current_cfg};
               `PDXG_ADDR_STATUS:    prdata <= {26'h0, timing_valid, state, extreme_seen};
               `PDXG_ADDR_TIMES:     prdata <= {off_time, on_time};
               `PDXG_ADDR_CURRENT:   prdata <= {12'h000, high_charge_code, high_discharge_code,
                                                low_charge_code, low_discharge_code};
               default:              prdata <= 32'h0000_0000;
            endcase
         end
         if (wr) begin
            case (paddr)
               `PDXG_ADDR_CTRL: begin
                  half_bridge_mode_select <= pwdata[`PDXG_CTRL_MODE_MSB:`PDXG_CTRL_MODE_LSB];
                  generator_mode          <= pwdata[`PDXG_CTRL_GENMODE];
                  generator_detect_enable <= pwdata[`PDXG_CTRL_GEN_DET_EN];
                  reg_bank                <= pwdata[`PDXG_CTRL_BANK];
               end
               `PDXG_ADDR_FW_PROT:  freewheel_protection_time <= pwdata[15:0];
               `PDXG_ADDR_ACT_PROT: active_protection_time    <= pwdata[15:0];
               // The bank bit steers which current configuration a write may update.
               `PDXG_ADDR_ICHG_ACT:  if (!reg_bank) active_charge_current_cfg <= pwdata[14:0];
               `PDXG_ADDR_IDCHG_ACT: if (!reg_bank) active_discharge_current_cfg <= pwdata[14:0];
               `PDXG_ADDR_ICHG_FW:   if (reg_bank) freewheel_current_cfg <= pwdata[14:0];
               default: begin
               end
            endcase
         end
      end
   end
endmodule

// [sim/pdxg_gate_ctrl_asserts.sv]
// Concurrent checks on the ports of the duty-extreme gate control.
`timescale 1ns/1ps
`include "pdxg_regs.vh"
module pdxg_gate_ctrl_checker (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        gate_high_on,
   input wire        gate_low_on,
   input wire [4:0]  high_charge_code,
   input wire [4:0]  high_discharge_code,
   input wire        timing_valid,
   input wire        generator_detect_enable
);
   reg  [1:0] mode;
   wire       wr_ok;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   // Shadow of the mode field, so the passive side can be named without seeing the body.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= `PDXG_MODE_LS;
      end else if (wr_ok && paddr == `PDXG_ADDR_CTRL) begin
         mode <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("no pready in the cycle after setup");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read returned nonzero data");
   detect_en_a: assert property (wr_ok && paddr == `PDXG_ADDR_CTRL |=>
      generator_detect_enable == $past(pwdata[`PDXG_CTRL_GEN_DET_EN]))
      else $error("detect enable does not follow control write");
   no_overlap_a: assert property (!(gate_high_on && gate_low_on))
      else $error("both gates on together");
   passive_high_a: assert property ((!timing_valid)[*3] ##1
      (!timing_valid && mode == `PDXG_MODE_LS) |-> !gate_high_on)
      else $error("high gate on at extreme duty in low-side mode");
   passive_low_a: assert property ((!timing_valid)[*3] ##1
      (!timing_valid && mode == `PDXG_MODE_HS) |-> !gate_low_on)
      else $error("low gate on at extreme duty in high-side mode");
   fw_codes_a: assert property (mode == `PDXG_MODE_LS && $stable(mode) |->
      high_charge_code == high_discharge_code)
      else $error("freewheel charge and discharge codes differ");
endmodule
bind pdxg_gate_ctrl pdxg_gate_ctrl_checker u_pdxg_gate_ctrl_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .gate_high_on(gate_high_on), .gate_low_on(gate_low_on),
   .high_charge_code(high_charge_code), .high_discharge_code(high_discharge_code),
   .timing_valid(timing_valid), .generator_detect_enable(generator_detect_enable));

// [sim/pdxg_pwm_host.sv]
// Host-side PWM source that drives the gate control's PWM input.
`timescale 1ns/1ps
module pdxg_pwm_host (
   input  wire        pclk,
   input  wire        run,
   input  wire [15:0] on_cycles,
   input  wire [15:0] off_cycles,
   output reg         pwm_out
);
   reg [15:0] cnt;
   initial begin
      pwm_out = 1'b0;
      cnt = 16'h0000;
   end
   // A stop only takes effect after an off phase, so every period handed out is whole.
   always @(posedge pclk) begin
      if (cnt != 16'h0000) begin
         cnt <= cnt - 16'h0001;
      end else if (pwm_out) begin
         pwm_out <= 1'b0;
         cnt <= off_cycles - 16'h0001;
      end else if (run) begin
         pwm_out <= 1'b1;
         cnt <= on_cycles - 16'h0001;
      end
   end
endmodule

// [sim/pdxg_gate_ctrl_bench.sv]
// Self-checking bench of the duty-extreme gate control.
`timescale 1ns/1ps
`include "pdxg_regs.vh"
module pdxg_gate_ctrl_bench;
   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic        err;
   } pdxg_row_t;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, pwm_in, gate_high_on, gate_low_on, timing_valid, gen_en, er;
   logic [4:0]  hcc, hdc, lcc, ldc;
   logic        run = 1'b0, opp, tv;
   logic [15:0] on_cyc = 16'h0001, off_cyc = 16'h0001;
   integer      failures = 0, samples_checked = 0, i, lat;
   pdxg_row_t   rows [0:15];
   always #12.5 pclk = ~pclk;
   pdxg_gate_ctrl u_pdxg_gate_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_in(pwm_in), .gate_high_on(gate_high_on),
      .gate_low_on(gate_low_on), .high_charge_code(hcc), .high_discharge_code(hdc),
      .low_charge_code(lcc), .low_discharge_code(ldc), .timing_valid(timing_valid),
      .generator_detect_enable(gen_en));
   pdxg_pwm_host u_pdxg_pwm_host (.pclk(pclk), .run(run), .on_cycles(on_cyc),
      .off_cycles(off_cyc), .pwm_out(pwm_in));
   task results;
      begin
         $display("checks %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task check_range(input string name, input integer lo, input integer hi, input integer got);
      begin
         samples_checked = samples_checked + 1;
         if (got < lo || got > hi) begin
            failures = failures + 1;
            $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
         end
      end
   endtask
   // Called right after a rising edge; the extra edge at the end keeps strobes from toggling
   // twice in one time step when transfers follow each other.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
            output logic e);
      integer n;
      begin
         psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n = n + 1;
         end
         if (pready !== 1'b1) begin
            failures = failures + 1;
            $display("Error pready expected 1 seen %b", pready);
         end
         q = prdata;
         e = pslverr;
         psel <= 1'b0; penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // Only the second half of the run is judged, after the classification has settled.
   task pwm_run(input logic hi, input logic [15:0] on, input logic [15:0] off);
      integer k, cnt;
      logic   prev, sprev, sel;
      begin
         on_cyc <= on; off_cyc <= off; run <= 1'b1;
         lat = -1; cnt = -1; opp = 1'b0; prev = 1'b0; sprev = 1'b0;
         for (k = 0; k < 8 * (on + off); k = k + 1) begin
            @(posedge pclk);
            sel = hi ? gate_high_on : gate_low_on;
            if (k > 4 * (on + off) && (hi ? gate_low_on : gate_high_on) === 1'b1) opp = 1'b1;
            if (pwm_in === 1'b1 && prev === 1'b0) cnt = 0;
            else if (cnt >= 0) cnt = cnt + 1;
            if (sel === 1'b1 && sprev === 1'b0 && cnt >= 0) lat = cnt;
            prev = pwm_in;
            sprev = sel;
         end
         tv = timing_valid;
         run <= 1'b0;
         repeat (2 * (on + off) + 40) @(posedge pclk);
      end
   endtask
   initial begin
      #(25 * 30000);
      failures = failures + 1;
      results();
   end
   initial begin
      rows[0] = {1'b0, `PDXG_ADDR_CTRL, 32'h0, `PDXG_CTRL_RESET, 1'b0};
      rows[1] = {1'b0, `PDXG_ADDR_FW_PROT, 32'h0, `PDXG_FW_PROT_RESET, 1'b0};
      rows[2] = {1'b0, `PDXG_ADDR_ACT_PROT, 32'h0, `PDXG_ACT_PROT_RESET, 1'b0};
      rows[3] = {1'b0, `PDXG_ADDR_ICHG_ACT, 32'h0, `PDXG_CODE_RESET, 1'b0};
      rows[4] = {1'b0, `PDXG_ADDR_IDCHG_ACT, 32'h0, `PDXG_CODE_RESET, 1'b0};
      rows[5] = {1'b0, `PDXG_ADDR_ICHG_FW, 32'h0, `PDXG_CODE_RESET, 1'b0};
      rows[6] = {1'b0, 12'h030, 32'h0, 32'h0, 1'b1};
      rows[7] = {1'b1, `PDXG_ADDR_ICHG_ACT, 32'h1F, 32'h0, 1'b0};
      rows[8] = {1'b0, `PDXG_ADDR_ICHG_ACT, 32'h0, 32'h1F, 1'b0};
      rows[9] = {1'b1, `PDXG_ADDR_IDCHG_ACT, 32'h1F, 32'h0, 1'b0};
      rows[10] = {1'b0, `PDXG_ADDR_IDCHG_ACT, 32'h0, 32'h1F, 1'b0};
      rows[11] = {1'b1, `PDXG_ADDR_ICHG_FW, 32'h3E0, 32'h0, 1'b0};
      rows[12] = {1'b0, `PDXG_ADDR_ICHG_FW, 32'h0, 32'h0, 1'b0};
      rows[13] = {1'b1, `PDXG_ADDR_FW_PROT, 32'h8, 32'h0, 1'b0};
      rows[14] = {1'b1, `PDXG_ADDR_ACT_PROT, 32'h6, 32'h0, 1'b0};
      rows[15] = {1'b0, `PDXG_ADDR_FW_PROT, 32'h0, 32'h8, 1'b0};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("gen_en", 32'h1, {31'h0, gen_en});
      check("codes", 32'h0, {12'h0, hcc, hdc, lcc, ldc});
      for (i = 0; i < 16; i = i + 1) begin
         apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, er);
         check("pslverr", {31'h0, rows[i].err}, {31'h0, er});
         if (!rows[i].wr) check("prdata", rows[i].exp, rd);
      end
      check("low_charge", 32'h1F, {27'h0, lcc});
      check("low_discharge", 32'h1F, {27'h0, ldc});
      $display("test table done");
      apb(1'b1, `PDXG_ADDR_CTRL, 32'h19, rd, er);
      apb(1'b1, `PDXG_ADDR_ICHG_FW, 32'h140, rd, er);
      apb(1'b1, `PDXG_ADDR_ICHG_ACT, 32'h03, rd, er);
      apb(1'b0, `PDXG_ADDR_ICHG_ACT, 32'h0, rd, er);
      check("bank1 ichg_act", 32'h1F, rd);
      check("fw codes", 32'h14A, {22'h0, hcc, hdc});
      apb(1'b1, `PDXG_ADDR_CTRL, 32'h09, rd, er);
      $display("test bank done");
      pwm_run(1'b0, 16'd20, 16'd20);
      check("normal valid", 32'h1, {31'h0, tv});
      check("normal freewheel", 32'h1, {31'h0, opp});
      apb(1'b1, `PDXG_ADDR_CTRL, 32'h01, rd, er);
      pwm_run(1'b0, 16'd30, 16'd3);
      check("high duty valid", 32'h0, {31'h0, tv});
      check("high duty opposite", 32'h0, {31'h0, opp});
      check_range("high duty delay", 8, 12, lat);
      pwm_run(1'b0, 16'd3, 16'd30);
      check("low duty valid", 32'h0, {31'h0, tv});
      check("low duty opposite", 32'h0, {31'h0, opp});
      check_range("low duty delay", 6, 10, lat);
      apb(1'b1, `PDXG_ADDR_CTRL, 32'h02, rd, er);
      pwm_run(1'b1, 16'd30, 16'd3);
      check("hs opposite", 32'h0, {31'h0, opp});
      check_range("hs delay", 8, 12, lat);
      apb(1'b1, `PDXG_ADDR_CTRL, 32'h05, rd, er);
      pwm_run(1'b0, 16'd20, 16'd20);
      check("gen valid", 32'h1, {31'h0, tv});
      check("gen active high", 32'h1, {31'h0, opp});
      check("gen high charge", 32'h1F, {27'h0, hcc});
      $display("test duty done");
      run <= 1'b1;
      repeat (100) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("reset outputs", 32'h1, {28'h0, gate_high_on, gate_low_on, timing_valid, gen_en});
      presetn <= 1'b1;
      run <= 1'b0;
      @(posedge pclk);
      apb(1'b0, `PDXG_ADDR_CTRL, 32'h0, rd, er);
      check("ctrl after reset", `PDXG_CTRL_RESET, rd);
      $display("test reset done");
      results();
   end
endmodule
